// ==== inc/sync_serial_port_regs.svh ====
`ifndef SYNC_SERIAL_PORT_REGS_SVH
`define SYNC_SERIAL_PORT_REGS_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define SSP_ADDR_CONFIG   16'h7040
`define SSP_ADDR_CONTROL  16'h7041
`define SSP_ADDR_STATUS   16'h7042
`define SSP_ADDR_BAUD     16'h7044
`define SSP_ADDR_RX_EMU   16'h7046
`define SSP_ADDR_RX_BUF   16'h7047
`define SSP_ADDR_TX_BUF   16'h7048
`define SSP_ADDR_SHIFT    16'h7049
`define SSP_ADDR_FIFO_TX  16'h704A
`define SSP_ADDR_FIFO_RX  16'h704B
`define SSP_ADDR_FIFO_TIM 16'h704C
`define SSP_ADDR_PRIO     16'h704F

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CFG_SWRST_BIT     7
`define CFG_POL_BIT       6
`define CFG_LEN_MSB       3
`define CTL_OVR_IE_BIT    4
`define CTL_PHASE_BIT     3
`define CTL_CTRL_BIT      2
`define CTL_TRANSMIT_DRIVE_ENABLE_BIT      1
`define CTL_IE_BIT        0
`define STS_OVR_BIT       7
`define STS_DONE_BIT      6
`define STS_FULL_BIT      5
`define PRI_3WIRE_BIT     0

// ----------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------
`define CFG_RST           8'h00
`define CFG_WMASK         8'hCF
`define CTL_RST           5'h00
`define BAUD_RST          7'h00
`define PRI_RST           1'h0
`define SYNC_RST          4'h8

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define BAUD_SLOW_MAX     7'h02
`define DIV_MIN           8'h04

`endif

// ==== inc/sync_serial_port_pkg.sv ====
package sync_serial_port_pkg;

    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b01,
        ST_SHIFT = 2'b10
    } xfer_state_t;

endpackage

// ==== src/pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output var  logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            meta_q <= RST_VAL;
            sync_o <= RST_VAL;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

`default_nettype wire

// ==== src/sync_serial_port_core.sv ====
// Function
// [R1] control bit selects controller or target role
// [R2] controller: clock out, send and sample lines
// [R3] target: external clock, swapped data lines
// [R4] controller write starts transfer, MSB first
// [R5] every bit out matched by one in
// [R6] finished character copied to receive buffer
// [R7] completion sets flag, interrupt when enabled
// [R8] pending transmit buffer continues, else clock stops
// [R9] divider sets controller bit rate
// [R10] far clock at most quarter core clock
// [R11] target transmit buffer passes when idle
// [R12] transmit_drive_enable off floats output, character completes
// [R13] high select halts target, floats output
// [R14] controller drives select low during transfer
// [R15] phase bit moves data half cycle ahead
// [R16] three-wire controller uses bidirectional out line
// [R17] three-wire target uses bidirectional in line
// [R18] left-justified data, four-bit length field
// [R19] one receive interrupt, fifo line idle
// [R20] status shows overrun, done, buffer full
// [R21] receive buffer read clears done flag
// [R22] unread reload sets overrun, software clears
// [R23] idle controller clock rests at polarity
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_port_regs.svh"

module sync_serial_port_core
    import sync_serial_port_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output var  logic [15:0] rdata_o,
    input  wire logic        serial_clock_line_i,
    output var  logic        serial_clock_line_o,
    output var  logic        serial_clock_line_oe_n_o,
    input  wire logic        periph_in_ctrl_out_i,
    output var  logic        periph_in_ctrl_out_o,
    output var  logic        periph_in_ctrl_out_oe_n_o,
    input  wire logic        periph_out_ctrl_in_i,
    output var  logic        periph_out_ctrl_in_o,
    output var  logic        periph_out_ctrl_in_oe_n_o,
    input  wire logic        target_select_n_i,
    output var  logic        target_select_n_o,
    output var  logic        target_select_n_oe_n_o,
    output var  logic        rx_irq_o,
    output var  logic        tx_fifo_irq_o
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [3:0]  pins_s;
    logic        sclk_s;
    logic        simo_s;
    logic        somi_s;
    logic        sel_n_s;

    pin_sync #(
        .WIDTH   (4),
        .RST_VAL (`SYNC_RST)
    ) u_pin_sync (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .async_i ({target_select_n_i, periph_out_ctrl_in_i,
                   periph_in_ctrl_out_i, serial_clock_line_i}),
        .sync_o  (pins_s)
    );

    assign sclk_s  = pins_s[0];
    assign simo_s  = pins_s[1];
    assign somi_s  = pins_s[2];
    assign sel_n_s = pins_s[3];

    // ----------------------------------------------------------------
    // registers and decode
    // ----------------------------------------------------------------
    logic [7:0]  cfg_q;
    logic [4:0]  ctl_q;
    logic [6:0]  baud_q;
    logic        three_wire_q;
    logic [15:0] txbuf_q;
    logic [15:0] sh_q;
    logic [15:0] sh_d;
    logic [15:0] rxbuf_q;
    logic        full_q;
    logic        done_q;
    logic        ovr_q;
    xfer_state_t state_q;
    logic [4:0]  bitcnt_q;
    logic        half_q;
    logic [7:0]  tmr_q;
    logic        tx_bit_q;
    logic        tx_bit_d;
    logic        sclk_prev_q;

    logic        eng_rst;
    logic        pol;
    logic        phase;
    logic        is_ctrl;
    logic        transmit_drive_enable;
    logic [4:0]  len;
    logic        wr_sh;
    logic        wr_tx;
    logic        rd_rx;
    logic        promote;
    logic        start;

    // clearing the reset bit holds the engine and flags in reset
    assign eng_rst = srst_i | ~cfg_q[`CFG_SWRST_BIT];
    assign pol     = cfg_q[`CFG_POL_BIT];
    assign phase   = ctl_q[`CTL_PHASE_BIT];
    assign is_ctrl = ctl_q[`CTL_CTRL_BIT];                       // [R1]
    assign transmit_drive_enable    = ctl_q[`CTL_TRANSMIT_DRIVE_ENABLE_BIT];
    assign len     = {1'b0, cfg_q[`CFG_LEN_MSB:0]} + 5'h01;      // [R18]
    assign wr_sh   = wr_i && (addr_i == `SSP_ADDR_SHIFT);
    assign wr_tx   = wr_i && (addr_i == `SSP_ADDR_TX_BUF);
    assign rd_rx   = rd_i && (addr_i == `SSP_ADDR_RX_BUF);
    assign promote = (state_q == ST_IDLE) && full_q;
    assign start   = is_ctrl && (state_q == ST_IDLE) && (wr_sh || wr_tx || full_q); // [R4]

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            cfg_q        <= `CFG_RST;
            ctl_q        <= `CTL_RST;
            baud_q       <= `BAUD_RST;
            three_wire_q <= `PRI_RST;
        end
        else if (wr_i)
        begin
            case (addr_i)
                `SSP_ADDR_CONFIG:  cfg_q        <= wdata_i[7:0] & `CFG_WMASK;
                `SSP_ADDR_CONTROL: ctl_q        <= wdata_i[4:0];
                `SSP_ADDR_BAUD:    baud_q       <= wdata_i[6:0];
                `SSP_ADDR_PRIO:    three_wire_q <= wdata_i[`PRI_3WIRE_BIT];
                default:           cfg_q        <= cfg_q;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            txbuf_q <= '0;
        else if (wr_tx)
            txbuf_q <= wdata_i;                                  // [R18]
    end

    // ----------------------------------------------------------------
    // bit timing
    // ----------------------------------------------------------------
    logic [7:0]  div;
    logic [7:0]  half1;
    logic [7:0]  half2;
    logic        ctrl_a;
    logic        ctrl_b;
    logic        tgt_a;
    logic        tgt_b;
    logic        rise;
    logic        fall;
    logic        ev_a;
    logic        ev_b;
    logic        sample;
    logic        rx_in;
    logic [15:0] sh_shift;
    logic [4:0]  cnt_after;
    logic        char_done;

    // low divider values all give the fastest rate
    assign div    = (baud_q <= `BAUD_SLOW_MAX) ? `DIV_MIN : {1'b0, baud_q} + 8'h01; // [R9]
    // odd divider: first half takes the extra cycle
    assign half2  = div >> 1;
    assign half1  = div - half2;
    assign ctrl_a = is_ctrl && (state_q == ST_SHIFT) && !half_q
                    && (tmr_q == half1 - 8'h01);
    assign ctrl_b = is_ctrl && (state_q == ST_SHIFT) && half_q
                    && (tmr_q == half2 - 8'h01);

    // edge finding needs the far clock slow against ours
    assign rise   = sclk_s && !sclk_prev_q;                      // [R10]
    assign fall   = !sclk_s && sclk_prev_q;
    assign tgt_a  = !is_ctrl && !sel_n_s && (pol ? fall : rise); // [R3] [R13]
    assign tgt_b  = !is_ctrl && !sel_n_s && (pol ? rise : fall); // [R13]
    assign ev_a   = ctrl_a || tgt_a;
    assign ev_b   = ctrl_b || tgt_b;
    assign sample = phase ? ev_a : ev_b;                         // [R15]

    always_comb
    begin
        if (three_wire_q)
            rx_in = is_ctrl ? simo_s : somi_s;                   // [R16] [R17]
        else
            rx_in = is_ctrl ? somi_s : simo_s;                   // [R2] [R3]
    end

    assign sh_shift  = {sh_q[14:0], rx_in};                      // [R4] [R5]
    assign cnt_after = bitcnt_q + {4'h0, sample};
    assign char_done = ev_b && (cnt_after == len);

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            sclk_prev_q <= 1'b0;
        else
            sclk_prev_q <= sclk_s;
    end

    always_ff @(posedge clk_i)
    begin
        if (eng_rst || !is_ctrl || state_q == ST_IDLE)
        begin
            tmr_q               <= '0;
            half_q              <= 1'b0;
            serial_clock_line_o <= pol;                          // [R23]
        end
        else if (ctrl_a)
        begin
            tmr_q               <= '0;
            half_q              <= 1'b1;
            serial_clock_line_o <= ~pol;                         // [R2]
        end
        else if (ctrl_b)
        begin
            tmr_q               <= '0;
            half_q              <= 1'b0;
            serial_clock_line_o <= pol;
        end
        else
            tmr_q <= tmr_q + 8'h01;
    end

    // ----------------------------------------------------------------
    // shift engine
    // ----------------------------------------------------------------
    always_comb
    begin
        sh_d = sh_q;
        if (eng_rst)
            sh_d = '0;
        else if (char_done && full_q)
            sh_d = txbuf_q;                                      // [R8] [R11]
        else if (sample)
            sh_d = sh_shift;                                     // [R5]
        else if (promote)
            sh_d = txbuf_q;                                      // [R11]
        else if (wr_sh || (wr_tx && state_q == ST_IDLE))
            sh_d = wdata_i;                                      // [R4] [R11]
    end

    // with phase set the line follows the shift head at once
    assign tx_bit_d = phase ? sh_d[15] : (ev_a ? sh_q[15] : tx_bit_q); // [R15] [R4]

    always_ff @(posedge clk_i)
    begin
        sh_q     <= sh_d;
        tx_bit_q <= eng_rst ? 1'b0 : tx_bit_d;
    end

    always_ff @(posedge clk_i)
    begin
        if (eng_rst)
            bitcnt_q <= '0;
        else if (char_done)
            bitcnt_q <= '0;
        else if (sample)
            bitcnt_q <= cnt_after;
    end

    always_ff @(posedge clk_i)
    begin
        if (eng_rst)
            state_q <= ST_IDLE;
        else
        begin
            case (state_q)
                ST_IDLE:
                    if (start || tgt_a)
                        state_q <= ST_SHIFT;                     // [R4]
                ST_SHIFT:
                    if (char_done && !(is_ctrl && full_q))
                        state_q <= ST_IDLE;                      // [R8]
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (eng_rst)
            full_q <= 1'b0;
        else if (wr_tx && state_q == ST_SHIFT)
            full_q <= 1'b1;
        else if ((char_done && full_q) || promote)
            full_q <= 1'b0;                                      // [R8]
    end

    // ----------------------------------------------------------------
    // receive side and flags
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (eng_rst)
            rxbuf_q <= '0;
        else if (char_done)
            rxbuf_q <= sample ? sh_shift : sh_q;                 // [R6]
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (eng_rst)
            done_q <= 1'b0;
        else if (char_done)
            done_q <= 1'b1;                                      // [R7]
        else if (rd_rx)
            done_q <= 1'b0;                                      // [R21]
    end

    always_ff @(posedge clk_i)
    begin
        if (eng_rst)
            ovr_q <= 1'b0;
        else if (char_done && done_q && !rd_rx)
            ovr_q <= 1'b1;                                       // [R22]
        else if (wr_i && addr_i == `SSP_ADDR_STATUS && wdata_i[`STS_OVR_BIT])
            ovr_q <= 1'b0;                                       // [R22]
    end

    // ----------------------------------------------------------------
    // pin drivers and interrupt
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            serial_clock_line_oe_n_o  <= 1'b1;
            periph_in_ctrl_out_o      <= 1'b0;
            periph_in_ctrl_out_oe_n_o <= 1'b1;
            periph_out_ctrl_in_o      <= 1'b0;
            periph_out_ctrl_in_oe_n_o <= 1'b1;
            target_select_n_o         <= 1'b1;
            target_select_n_oe_n_o    <= 1'b1;
            rx_irq_o                  <= 1'b0;
            tx_fifo_irq_o             <= 1'b0;
        end
        else
        begin
            serial_clock_line_oe_n_o  <= ~is_ctrl;               // [R1]
            periph_in_ctrl_out_o      <= tx_bit_d;
            periph_in_ctrl_out_oe_n_o <= ~(is_ctrl && transmit_drive_enable);     // [R2] [R12] [R16]
            periph_out_ctrl_in_o      <= tx_bit_d;
            periph_out_ctrl_in_oe_n_o <= ~(!is_ctrl && transmit_drive_enable && !sel_n_s); // [R3] [R12] [R13] [R17]
            target_select_n_o         <= ~(is_ctrl && state_q == ST_SHIFT); // [R14]
            target_select_n_oe_n_o    <= ~is_ctrl;
            rx_irq_o                  <= (done_q && ctl_q[`CTL_IE_BIT])
                                         || (ovr_q && ctl_q[`CTL_OVR_IE_BIT]); // [R7] [R19]
            tx_fifo_irq_o             <= 1'b0;                   // [R19]
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (srst_i || !rd_i)
            rdata_o <= '0;
        else
        begin
            case (addr_i)
                `SSP_ADDR_CONFIG:  rdata_o <= {8'h00, cfg_q};
                `SSP_ADDR_CONTROL: rdata_o <= {11'h000, ctl_q};
                `SSP_ADDR_STATUS:  rdata_o <= {8'h00, ovr_q, done_q, full_q, 5'h00}; // [R20]
                `SSP_ADDR_BAUD:    rdata_o <= {9'h000, baud_q};
                `SSP_ADDR_RX_EMU:  rdata_o <= rxbuf_q;
                `SSP_ADDR_RX_BUF:  rdata_o <= rxbuf_q;
                `SSP_ADDR_TX_BUF:  rdata_o <= txbuf_q;
                `SSP_ADDR_SHIFT:   rdata_o <= sh_q;
                `SSP_ADDR_PRIO:    rdata_o <= {15'h0000, three_wire_q};
                default:           rdata_o <= '0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_clock_dir_role: assert property (@(posedge clk_i) disable iff (srst_i) // [R1]
        1'b1 |=> (serial_clock_line_oe_n_o == !$past(is_ctrl)))
        else $error("clock pin direction does not follow role");

    chk_idle_clock_level: assert property (@(posedge clk_i) disable iff (eng_rst) // [R23]
        (is_ctrl && state_q == ST_IDLE) |=> (serial_clock_line_o == $past(pol)))
        else $error("idle controller clock not at polarity level");

    chk_done_copy_rx: assert property (@(posedge clk_i) disable iff (eng_rst) // [R6]
        (char_done && sample) |=> (rxbuf_q == $past(sh_shift)) && done_q)
        else $error("finished character not copied");

    chk_read_clears_done: assert property (@(posedge clk_i) disable iff (eng_rst) // [R21]
        (rd_rx && !char_done) |=> !done_q)
        else $error("receive read did not clear done flag");

    chk_overrun_set: assert property (@(posedge clk_i) disable iff (eng_rst) // [R22]
        (char_done && done_q && !rd_rx) |=> ovr_q)
        else $error("overrun not raised");

    chk_overrun_hold: assert property (@(posedge clk_i) disable iff (eng_rst) // [R22]
        (ovr_q && !(wr_i && addr_i == `SSP_ADDR_STATUS && wdata_i[`STS_OVR_BIT]))
            |=> ovr_q)
        else $error("overrun dropped without software clear");

    chk_irq_follows_flag: assert property (@(posedge clk_i) disable iff (eng_rst) // [R7]
        (done_q && ctl_q[`CTL_IE_BIT]) |=> rx_irq_o)
        else $error("receive interrupt missing");

    chk_select_halts: assert property (@(posedge clk_i) disable iff (eng_rst) // [R13]
        (!is_ctrl && sel_n_s) |-> !ev_a && !ev_b ##1 periph_out_ctrl_in_oe_n_o)
        else $error("deselected target still shifting or driving");

    chk_transmit_drive_enable_floats: assert property (@(posedge clk_i) disable iff (srst_i) // [R12]
        !transmit_drive_enable |=> periph_out_ctrl_in_oe_n_o && periph_in_ctrl_out_oe_n_o)
        else $error("output driven with transmit_drive_enable off");

    chk_half_period_min: assert property (@(posedge clk_i) disable iff (eng_rst) // [R9]
        ctrl_a |=> !ev_b)
        else $error("controller half period below two cycles");

    chk_select_drive: assert property (@(posedge clk_i) disable iff (srst_i) // [R14]
        (is_ctrl && state_q == ST_SHIFT) |=> !target_select_n_o)
        else $error("select not low during controller transfer");

    chk_continue_pending: assert property (@(posedge clk_i) disable iff (eng_rst) // [R8]
        (is_ctrl && char_done && full_q) |=> (state_q == ST_SHIFT) && (full_q == $past(wr_tx))
            && (sh_q == $past(txbuf_q)))
        else $error("pending character not continued");

endmodule

`default_nettype wire

// ==== sim/far_peer.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// far target: sends a fixed word after each select, then zeros
// ----------------------------------------------------------------
module far_peer #(
    parameter logic [15:0] REPLY = 16'hA5C3
) (
    input  wire logic        sclk_i,
    input  wire logic        sel_n_i,
    input  wire logic        sdi_i,
    output var  logic        sdo_o,
    output var  logic [15:0] got_o
);
    logic [15:0] tx_q;
    initial
    begin
        sdo_o = 1'b0;
        got_o = 16'h0000;
        tx_q  = REPLY;
    end
    always @(negedge sel_n_i)
    begin
        tx_q  <= REPLY;
        got_o <= 16'h0000;
    end
    // out on the rising edge, in on the falling one, only while selected
    always @(posedge sclk_i)
    begin
        if (!sel_n_i)
        begin
            sdo_o <= tx_q[15];
            tx_q  <= {tx_q[14:0], 1'b0};
        end
    end
    always @(negedge sclk_i)
    begin
        if (!sel_n_i)
            got_o <= {got_o[14:0], sdi_i};
    end
    // released line has no pull: show the inverse, not a stale bit
    always @(posedge sel_n_i)
        sdo_o <= ~sdo_o;
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_port_regs.svh"
module testbench;
    logic        clk_i, srst_i, wr_i, rd_i;
    logic [15:0] addr_i, wdata_i, rdata_o, peer_got, v, q;
    logic        sclk_o, sclk_oe_n, pico_o, pico_oe_n, poci_o, poci_oe_n;
    logic        sel_o, sel_oe_n, irq_o, fifo_irq_o, peer_sdo;
    logic        tb_sclk, tb_pico, tb_sel, sclk_w, pico_w, poci_w, sel_w;
    int          error_cnt = 0;
    int          checks_done = 0;
    int          cyc_cnt = 0;
    // the pin level is the enabled driver, else the far side
    assign sclk_w = sclk_oe_n ? tb_sclk : sclk_o;
    assign pico_w = pico_oe_n ? tb_pico : pico_o;
    assign poci_w = poci_oe_n ? peer_sdo : poci_o;
    assign sel_w  = sel_oe_n ? tb_sel : sel_o;
    sync_serial_port_core u_dut (
        .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .serial_clock_line_i(sclk_w), .serial_clock_line_o(sclk_o),
        .serial_clock_line_oe_n_o(sclk_oe_n), .periph_in_ctrl_out_i(pico_w),
        .periph_in_ctrl_out_o(pico_o), .periph_in_ctrl_out_oe_n_o(pico_oe_n),
        .periph_out_ctrl_in_i(poci_w), .periph_out_ctrl_in_o(poci_o),
        .periph_out_ctrl_in_oe_n_o(poci_oe_n), .target_select_n_i(sel_w),
        .target_select_n_o(sel_o), .target_select_n_oe_n_o(sel_oe_n),
        .rx_irq_o(irq_o), .tx_fifo_irq_o(fifo_irq_o));
    far_peer u_peer (.sclk_i(sclk_w), .sel_n_i(sel_w), .sdi_i(pico_w),
        .sdo_o(peer_sdo), .got_o(peer_got));
    // ----------------------------------------------------------------
    // bus and check helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 d = rdata_o;
    endtask
    // far controller clock is asynchronous to the core, 64 ns period
    task automatic link_word(input logic [15:0] d, output logic [15:0] r);
        // quarter-ns offset keeps far edges off our clock edges
        #0.25;
        for (int i = 15; i >= 0; i--)
        begin
            tb_sclk = 1'b1;
            tb_pico = d[i];
            #32;
            r = {r[14:0], poci_w};
            tb_sclk = 1'b0;
            #32;
        end
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        rd(`SSP_ADDR_CONFIG, v);
        chk(v, 16'h0000);
        wr(`SSP_ADDR_CONFIG, 16'hFFFF);
        rd(`SSP_ADDR_CONFIG, v);
        chk(v, 16'h00CF);
        wr(16'h7043, 16'hFFFF);
        rd(16'h7043, v);
        chk(v, 16'h0000);
        rd(`SSP_ADDR_FIFO_TX, v);
        chk(v, 16'h0000);
        wr(`SSP_ADDR_CONFIG, 16'h008F);
        $display("test regs done");
    endtask
    task automatic t_ctrl();
        realtime t0;
        int      n;
        wr(`SSP_ADDR_BAUD, 16'h0005);
        wr(`SSP_ADDR_CONTROL, 16'h0007);
        wr(`SSP_ADDR_SHIFT, 16'h3C96);
        wr(`SSP_ADDR_TX_BUF, 16'h1234);
        rd(`SSP_ADDR_STATUS, v);
        chk(v, 16'h0020);
        chk({15'h0, sel_w}, 16'h0000);
        @(posedge sclk_w);
        t0 = $realtime;
        @(posedge sclk_w);
        chk(16'(int'(($realtime - t0) / 5.0)), 16'h0006);
        n = 0;
        while (irq_o !== 1'b1 && n < 400)
        begin
            @(posedge clk_i);
            n++;
        end
        chk({15'h0, irq_o}, 16'h0001);
        rd(`SSP_ADDR_RX_EMU, v);
        chk(v, 16'hA5C3);
        rd(`SSP_ADDR_STATUS, v);
        chk(v, 16'h0040);
        n = 0;
        while (sel_w !== 1'b1 && n < 400)
        begin
            @(posedge clk_i);
            n++;
        end
        chk({15'h0, sel_w}, 16'h0001);
        repeat (2) @(posedge clk_i);
        chk(peer_got, 16'h1234);
        chk({15'h0, sclk_w}, 16'h0000);
        rd(`SSP_ADDR_STATUS, v);
        chk(v, 16'h00C0);
        rd(`SSP_ADDR_RX_BUF, v);
        chk(v, 16'h0000);
        rd(`SSP_ADDR_STATUS, v);
        chk(v, 16'h0080);
        wr(`SSP_ADDR_STATUS, 16'h0080);
        rd(`SSP_ADDR_STATUS, v);
        chk(v, 16'h0000);
        chk({15'h0, irq_o}, 16'h0000);
        $display("test controller done");
    endtask
    task automatic t_three_wire();
        int n;
        wr(`SSP_ADDR_PRIO, 16'h0001);
        rd(`SSP_ADDR_PRIO, v);
        chk(v, 16'h0001);
        wr(`SSP_ADDR_CONTROL, 16'h0005);
        tb_pico <= 1'b1;
        wr(`SSP_ADDR_SHIFT, 16'h0000);
        chk({14'h0, poci_oe_n, pico_oe_n}, 16'h0003);
        n = 0;
        while (irq_o !== 1'b1 && n < 400)
        begin
            @(posedge clk_i);
            n++;
        end
        chk({15'h0, irq_o}, 16'h0001);
        rd(`SSP_ADDR_RX_BUF, v);
        chk(v, 16'hFFFF);
        wr(`SSP_ADDR_PRIO, 16'h0000);
        $display("test three-wire done");
    endtask
    task automatic t_target();
        wr(`SSP_ADDR_CONTROL, 16'h0002);
        wr(`SSP_ADDR_TX_BUF, 16'hC3A5);
        rd(`SSP_ADDR_STATUS, v);
        chk(v, 16'h0000);
        tb_sel = 1'b0;
        #100;
        link_word(16'h5A0F, q);
        #100;
        chk(q, 16'hC3A5);
        rd(`SSP_ADDR_RX_BUF, v);
        chk(v, 16'h5A0F);
        tb_sel = 1'b1;
        #100;
        chk({15'h0, poci_oe_n}, 16'h0001);
        link_word(16'hFFFF, q);
        #100;
        rd(`SSP_ADDR_STATUS, v);
        chk(v, 16'h0000);
        tb_sel = 1'b0;
        wr(`SSP_ADDR_CONTROL, 16'h0000);
        #50;
        chk({15'h0, poci_oe_n}, 16'h0001);
        wr(`SSP_ADDR_CONTROL, 16'h0002);
        #50;
        chk({15'h0, poci_oe_n}, 16'h0000);
        $display("test target done");
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // whole run needs about 900 cycles
    always @(posedge clk_i)
    begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 6000)
        begin
            error_cnt++;
            give_verdict();
        end
    end
    initial
    begin
        srst_i  = 1'b1;
        addr_i  = 16'h0000;
        wdata_i = 16'h0000;
        wr_i    = 1'b0;
        rd_i    = 1'b0;
        tb_sclk = 1'b0;
        tb_pico = 1'b0;
        tb_sel  = 1'b1;
        repeat (20) @(posedge clk_i);
        srst_i <= 1'b0;
        t_regs();
        t_ctrl();
        t_three_wire();
        t_target();
        give_verdict();
    end
endmodule
`default_nettype wire
